// File: hdl/reset_boot_sequencer.sv
// Functional notes
// - device reset low holds internal reset and every state at its initial value
// - internal reset release starts the processor in the selected boot mode
// - three boot modes: host load, emulator assisted, external ROM copy
// - host boot keeps CPU stalled, rest runs, host reaches memory
// - that bit in host boot releases the stall, CPU starts at zero
// - interrupt raised while stalled is not latched as a pending CPU interrupt
// - interrupt bit releases the stall in host and emulator boot, not in ROM boot
// - CPU clears the bit; while set, further interrupts are not accepted
// - ROM boot copies first 1 KB of chip select one to zero
// - narrow ROM bytes or halfwords packed into 32-bit words
// - ROM copy runs automatically as one single-frame block transfer
// - block transfer done releases the stall, execution starts at zero
// - device reset initialises core, test-port reset initialises emulation logic
// - only device reset release needed to boot; test port may stay reset
// - internal pulldown holds test-port reset asserted when undriven
// - first test-port reset rise after release latches the debug-mode pins
`timescale 1ns/10ps
`include "boot_consts.svh"

module reset_boot_sequencer (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  boot_mode_sel,
    input  wire logic [1:0]  rom_width_sel,
    input  wire logic        big_endian,
    input  wire logic        host_irq_set,
    input  wire logic        cpu_irq_clear,
    input  wire logic        host_mem_req,
    input  wire logic        host_mem_we,
    input  wire logic [31:0] host_mem_addr,
    input  wire logic [31:0] host_mem_wdata,
    input  wire logic [31:0] rom_data,
    input  wire logic        test_rst_drive_en,
    input  wire logic        test_rst_level,
    input  wire logic [1:0]  debug_mode_pins,
    output logic             core_rst_n,
    output logic             cpu_stall,
    output logic             cpu_start,
    output logic [31:0]      cpu_start_addr,
    output logic             host_to_cpu_irq,
    output logic             cpu_irq_event,
    output logic             host_mem_ready,
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic             ext_chip_select_one_n,
    output logic [9:0]       rom_addr,
    output logic [1:0]       boot_mode,
    output logic             copy_done,
    output logic             emu_logic_rst_n,
    output logic [1:0]       debug_mode,
    output logic             debug_mode_valid
);
    boot_pkg::seq_state_t state;
    boot_pkg::seq_state_t next_state;
    boot_pkg::rom_width_t rom_width;

    logic [7:0]  word_idx;
    logic        pack_wait;
    logic        word_done;
    logic [31:0] packed_word;

    // ==========================================
    // decode
    wire in_copy     = state == boot_pkg::ST_COPY;
    wire in_host     = state == boot_pkg::ST_HOST;
    wire in_emu      = state == boot_pkg::ST_EMU;
    wire in_run      = state == boot_pkg::ST_RUN;
    wire copy_finish = in_copy && word_done && word_idx == `COPY_LAST_WORD;
    wire pack_start  = in_copy && !pack_wait && !word_done;
    // host port is never stalled; it only yields while the copy owns memory
    wire host_take   = host_mem_req && host_mem_ready;
    // a set is refused while the bit stands, and never counts while stalled
    wire irq_accept  = host_irq_set && !host_to_cpu_irq;
    wire next_irq    = host_irq_set || (host_to_cpu_irq && !cpu_irq_clear);
    wire next_event  = irq_accept && in_run && !cpu_stall;
    wire next_stall  = next_state != boot_pkg::ST_RUN;
    wire next_start  = next_state == boot_pkg::ST_RUN && !in_run;

    assign host_mem_ready = !in_copy;
    assign cpu_start_addr = `BOOT_VECTOR;

    // ==========================================
    // boot sequence
    always_comb begin
        next_state = state;
        unique case (state)
            boot_pkg::ST_LATCH: begin
                // reserved code falls back to host boot, the safe stalled mode
                if (boot_mode_sel == boot_pkg::BOOT_ROM) begin
                    next_state = boot_pkg::ST_COPY;
                end else if (boot_mode_sel == boot_pkg::BOOT_EMU) begin
                    next_state = boot_pkg::ST_EMU;
                end else begin
                    next_state = boot_pkg::ST_HOST;
                end
            end
            boot_pkg::ST_HOST: begin
                if (host_to_cpu_irq) begin
                    next_state = boot_pkg::ST_RUN;
                end
            end
            boot_pkg::ST_EMU: begin
                // the emulator sets the same bit once its breakpoint is placed
                if (host_to_cpu_irq) begin
                    next_state = boot_pkg::ST_RUN;
                end
            end
            boot_pkg::ST_COPY: begin
                // interrupt bit has no say here, only the copy end
                if (copy_finish) begin
                    next_state = boot_pkg::ST_RUN;
                end
            end
            boot_pkg::ST_RUN: begin
                next_state = boot_pkg::ST_RUN;
            end
            default: begin
                next_state = boot_pkg::ST_LATCH;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= boot_pkg::ST_LATCH;
            core_rst_n <= 1'b0;
            cpu_stall  <= 1'b1;
            cpu_start  <= 1'b0;
        end else begin
            state      <= next_state;
            core_rst_n <= 1'b1;
            cpu_stall  <= next_stall;
            cpu_start  <= next_start;
        end
    end

    // ==========================================
    // strap capture at the first edge after release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            boot_mode <= boot_pkg::BOOT_EMU;
            rom_width <= boot_pkg::ROM_W8;
        end else if (state == boot_pkg::ST_LATCH) begin
            boot_mode <= boot_mode_sel;
            rom_width <= boot_pkg::rom_width_t'(rom_width_sel);
        end
    end

    // ==========================================
    // host-to-CPU interrupt bit, set wins over clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            host_to_cpu_irq <= 1'b0;
            cpu_irq_event   <= 1'b0;
        end else begin
            host_to_cpu_irq <= next_irq;
            cpu_irq_event   <= next_event;
        end
    end

    // ==========================================
    // ROM block copy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            word_idx  <= 8'h00;
            pack_wait <= 1'b0;
            copy_done <= 1'b0;
        end else begin
            if (pack_start) begin
                pack_wait <= 1'b1;
            end else if (word_done) begin
                pack_wait <= 1'b0;
            end
            if (in_copy && word_done) begin
                word_idx <= 8'(word_idx + 8'h01);
            end
            if (copy_finish) begin
                copy_done <= 1'b1;
            end
        end
    end

    // ==========================================
    // memory port: copy writes first, host otherwise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
        end else if (in_copy && word_done) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= `BOOT_VECTOR + {22'h000000, word_idx, 2'b00};
            mem_wdata <= packed_word;
        end else if (host_take) begin
            mem_req   <= 1'b1;
            mem_we    <= host_mem_we;
            mem_addr  <= host_mem_addr;
            mem_wdata <= host_mem_wdata;
        end else begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
        end
    end

    rom_word_packer u_packer (
        .mclk                  (mclk),
        .rst_n                 (rst_n),
        .start                 (pack_start),
        .word_addr             (word_idx),
        .width                 (rom_width),
        .big_endian            (big_endian),
        .rom_data              (rom_data),
        .ext_chip_select_one_n (ext_chip_select_one_n),
        .rom_addr              (rom_addr),
        .word                  (packed_word),
        .word_done             (word_done)
    );

    // test port runs on its own reset; boot never waits on it
    test_port_ctl u_test (
        .mclk              (mclk),
        .rst_n             (rst_n),
        .test_rst_drive_en (test_rst_drive_en),
        .test_rst_level    (test_rst_level),
        .debug_mode_pins   (debug_mode_pins),
        .emu_logic_rst_n   (emu_logic_rst_n),
        .debug_mode        (debug_mode),
        .debug_mode_valid  (debug_mode_valid)
    );

    // ==========================================
    // checks
    property p_start_boot;
        @(posedge mclk) disable iff (!rst_n)
        state == boot_pkg::ST_LATCH |=> state != boot_pkg::ST_LATCH;
    endproperty
    a_start_boot: assert property (p_start_boot) else $error("boot did not start");

    property p_host_release;
        @(posedge mclk) disable iff (!rst_n)
        in_host && host_to_cpu_irq |=> !cpu_stall && cpu_start;
    endproperty
    a_host_release: assert property (p_host_release) else $error("host boot not released");

    property p_emu_release;
        @(posedge mclk) disable iff (!rst_n)
        in_emu && host_to_cpu_irq |=> !cpu_stall && cpu_start;
    endproperty
    a_emu_release: assert property (p_emu_release) else $error("emu not released");

    property p_rom_no_irq_release;
        @(posedge mclk) disable iff (!rst_n)
        in_copy && !copy_finish |=> cpu_stall;
    endproperty
    a_rom_no_irq_release: assert property (p_rom_no_irq_release) else $error("stall dropped");

    property p_no_latch_stalled;
        @(posedge mclk) disable iff (!rst_n)
        cpu_stall |=> !cpu_irq_event;
    endproperty
    a_no_latch_stalled: assert property (p_no_latch_stalled) else $error("irq while stalled");

    property p_refuse_while_set;
        @(posedge mclk) disable iff (!rst_n)
        host_to_cpu_irq && host_irq_set |=> !cpu_irq_event && host_to_cpu_irq;
    endproperty
    a_refuse_while_set: assert property (p_refuse_while_set) else $error("irq accepted twice");

    property p_copy_release;
        @(posedge mclk) disable iff (!rst_n)
        copy_finish |=> cpu_start && !cpu_stall ##1 copy_done && !cpu_start;
    endproperty
    a_copy_release: assert property (p_copy_release) else $error("copy end no release");

    property p_copy_range;
        @(posedge mclk) disable iff (!rst_n)
        mem_we && boot_mode == boot_pkg::BOOT_ROM && !in_run |-> mem_addr < `COPY_BYTES;
    endproperty
    a_copy_range: assert property (p_copy_range) else $error("copy out of 1 KB");

    property p_strap_hold;
        @(posedge mclk) disable iff (!rst_n)
        state != boot_pkg::ST_LATCH && !in_run |=> $stable(boot_mode) && $stable(rom_width);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed in boot");

    property p_core_reset;
        @(posedge mclk) disable iff (!rst_n)
        !core_rst_n |-> cpu_stall && state == boot_pkg::ST_LATCH;
    endproperty
    a_core_reset: assert property (p_core_reset) else $error("reset state lost");

    property p_host_port_open;
        @(posedge mclk) disable iff (!rst_n)
        in_host && host_mem_req |=> mem_req && mem_addr == $past(host_mem_addr);
    endproperty
    a_host_port_open: assert property (p_host_port_open) else $error("host port blocked");

endmodule

// File: common/boot_consts.svh
`ifndef BOOT_CONSTS_SVH
`define BOOT_CONSTS_SVH

// ==========================================
// clock and timing
`define CLK_PERIOD_NS    8
`define ROM_ACCESS_NS    64
`define ROM_ACCESS_CYC   ((`ROM_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================
// boot copy geometry
`define BOOT_VECTOR      32'h0000_0000
`define COPY_BYTES       1024
`define COPY_LAST_WORD   8'hFF
`define ROM_AW           10

// ==========================================
// reset values
`define DEBUG_MODE_RST   2'h0
`define TEST_PREV_RST    1'h1

`endif

// File: common/boot_pkg.sv
package boot_pkg;

    typedef enum logic [1:0] {
        BOOT_EMU  = 2'b00,
        BOOT_HOST = 2'b01,
        BOOT_ROM  = 2'b10,
        BOOT_RSVD = 2'b11
    } boot_mode_t;

    typedef enum logic [1:0] {
        ROM_W8   = 2'b00,
        ROM_W16  = 2'b01,
        ROM_W32  = 2'b10,
        ROM_WRSV = 2'b11
    } rom_width_t;

    typedef enum logic [2:0] {
        ST_LATCH = 3'b000,
        ST_HOST  = 3'b001,
        ST_EMU   = 3'b010,
        ST_COPY  = 3'b011,
        ST_RUN   = 3'b100
    } seq_state_t;

endpackage

// File: hdl/rom_word_packer.sv
`timescale 1ns/10ps
`include "boot_consts.svh"

module rom_word_packer (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  start,
    input  wire logic [7:0]            word_addr,
    input  wire boot_pkg::rom_width_t  width,
    input  wire logic                  big_endian,
    input  wire logic [31:0]           rom_data,
    output logic                       ext_chip_select_one_n,
    output logic [`ROM_AW-1:0]         rom_addr,
    output logic [31:0]                word,
    output logic                       word_done
);
    localparam int W8_SPAN = 4 * `ROM_ACCESS_CYC + 1;

    logic       busy;
    logic [1:0] part;
    logic [3:0] cnt;

    // ==========================================
    // lane selection
    wire is8       = width == boot_pkg::ROM_W8;
    wire is16      = width == boot_pkg::ROM_W16;
    wire last_cyc  = cnt == 4'(`ROM_ACCESS_CYC - 1);
    wire [1:0] part_last = is8 ? 2'h3 : (is16 ? 2'h1 : 2'h0);
    wire last_part = part == part_last;
    wire [`ROM_AW-1:0] step = is8 ? 10'h001 : (is16 ? 10'h002 : 10'h004);
    // first unit lands low for little endian, high for big endian
    wire [31:0] le8  = {rom_data[7:0], word[31:8]};
    wire [31:0] be8  = {word[23:0], rom_data[7:0]};
    wire [31:0] le16 = {rom_data[15:0], word[31:16]};
    wire [31:0] be16 = {word[15:0], rom_data[15:0]};
    wire [31:0] next_word = is8 ? (big_endian ? be8 : le8) :
                            is16 ? (big_endian ? be16 : le16) : rom_data;

    assign ext_chip_select_one_n = ~busy;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy      <= 1'b0;
            part      <= 2'h0;
            cnt       <= 4'h0;
            rom_addr  <= 10'h000;
            word      <= 32'h0000_0000;
            word_done <= 1'b0;
        end else begin
            word_done <= busy && last_cyc && last_part;
            if (start && !busy) begin
                busy     <= 1'b1;
                part     <= 2'h0;
                cnt      <= 4'h0;
                rom_addr <= {word_addr, 2'b00};
            end else if (busy) begin
                cnt <= last_cyc ? 4'h0 : 4'(cnt + 4'h1);
                if (last_cyc) begin
                    word <= next_word;
                    if (last_part) begin
                        busy <= 1'b0;
                    end else begin
                        part     <= 2'(part + 2'h1);
                        rom_addr <= 10'(rom_addr + step);
                    end
                end
            end
        end
    end

    property p_w8_pack;
        @(posedge mclk) disable iff (!rst_n)
        start && !busy && is8 |-> ##W8_SPAN word_done;
    endproperty
    a_w8_pack: assert property (p_w8_pack) else $error("byte pack not four accesses");

endmodule

// File: hdl/test_port_ctl.sv
`timescale 1ns/10ps
`include "boot_consts.svh"

module test_port_ctl (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       test_rst_drive_en,
    input  wire logic       test_rst_level,
    input  wire logic [1:0] debug_mode_pins,
    output logic            emu_logic_rst_n,
    output logic [1:0]      debug_mode,
    output logic            debug_mode_valid
);
    logic prev;

    // ==========================================
    // undriven pin reads low: emulation logic held in reset
    wire test_rst_eff = test_rst_drive_en & test_rst_level;
    wire rise = test_rst_eff & ~prev;

    assign emu_logic_rst_n = test_rst_eff;

    // prev resets high so a pin already high at release is no transition
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev             <= `TEST_PREV_RST;
            debug_mode       <= `DEBUG_MODE_RST;
            debug_mode_valid <= 1'b0;
        end else begin
            prev <= test_rst_eff;
            if (rise && !debug_mode_valid) begin
                debug_mode       <= debug_mode_pins;
                debug_mode_valid <= 1'b1;
            end
        end
    end

    property p_debug_latch;
        @(posedge mclk) disable iff (!rst_n)
        rise && !debug_mode_valid |=> debug_mode_valid && debug_mode == $past(debug_mode_pins);
    endproperty
    a_debug_latch: assert property (p_debug_latch) else $error("debug pins not latched");

    property p_latch_once;
        @(posedge mclk) disable iff (!rst_n)
        debug_mode_valid |=> $stable(debug_mode);
    endproperty
    a_latch_once: assert property (p_latch_once) else $error("debug mode relatched");

    property p_pulldown;
        @(posedge mclk) disable iff (!rst_n)
        !test_rst_drive_en |-> !emu_logic_rst_n;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("undriven pin left emu out of reset");

endmodule

// File: test/boot_rom_model.sv
`timescale 1ns/10ps

// ==========================================
// external boot rom on chip select one
module boot_rom_model (
    input  wire logic        mclk,
    input  wire logic        cs_n,
    input  wire logic [9:0]  addr,
    output logic [31:0]      data
);
    logic [31:0] last = 32'h0;

    function automatic logic [7:0] rom_byte(input logic [9:0] a);
        return a[7:0] ^ {a[9:8], 6'h25};
    endfunction

    // narrow units sit in the low lanes, lane 0 holds the byte at addr
    wire logic [31:0] image_word = {rom_byte(addr + 10'h3), rom_byte(addr + 10'h2),
                                    rom_byte(addr + 10'h1), rom_byte(addr)};

    // deselected bus shows a moving pattern, never a stale word
    assign data = cs_n ? ~last : image_word;

    always_ff @(posedge mclk) begin
        last <= data;
    end
endmodule

// File: test/reset_boot_sequencer_tb.sv
`timescale 1ns/10ps

module reset_boot_sequencer_tb;
    // ==========================================
    // signals
    logic        mclk, rst_n, big_endian, host_irq_set, cpu_irq_clear, host_mem_req;
    logic        host_mem_we, test_rst_drive_en, test_rst_level, core_rst_n, cpu_stall;
    logic        cpu_start, host_to_cpu_irq, cpu_irq_event, host_mem_ready, mem_req, mem_we;
    logic        ext_chip_select_one_n, copy_done, emu_logic_rst_n, debug_mode_valid, rom_mon;
    logic        cur_be;
    logic [1:0]  boot_mode_sel, rom_width_sel, debug_mode_pins, boot_mode, debug_mode;
    logic [1:0]  cur_w;
    logic [9:0]  rom_addr;
    logic [31:0] host_mem_addr, host_mem_wdata, rom_data, cpu_start_addr, mem_addr, mem_wdata;
    int          errors = 0, samples_checked = 0, cycles = 0, words_seen = 0;

    reset_boot_sequencer dut_u (
        .mclk(mclk), .rst_n(rst_n), .boot_mode_sel(boot_mode_sel),
        .rom_width_sel(rom_width_sel), .big_endian(big_endian), .host_irq_set(host_irq_set),
        .cpu_irq_clear(cpu_irq_clear), .host_mem_req(host_mem_req), .host_mem_we(host_mem_we),
        .host_mem_addr(host_mem_addr), .host_mem_wdata(host_mem_wdata), .rom_data(rom_data),
        .test_rst_drive_en(test_rst_drive_en), .test_rst_level(test_rst_level),
        .debug_mode_pins(debug_mode_pins), .core_rst_n(core_rst_n), .cpu_stall(cpu_stall),
        .cpu_start(cpu_start), .cpu_start_addr(cpu_start_addr), .host_to_cpu_irq(host_to_cpu_irq),
        .cpu_irq_event(cpu_irq_event), .host_mem_ready(host_mem_ready), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .ext_chip_select_one_n(ext_chip_select_one_n), .rom_addr(rom_addr),
        .boot_mode(boot_mode), .copy_done(copy_done), .emu_logic_rst_n(emu_logic_rst_n),
        .debug_mode(debug_mode), .debug_mode_valid(debug_mode_valid)
    );

    boot_rom_model rom_u (.mclk(mclk), .cs_n(ext_chip_select_one_n), .addr(rom_addr),
                          .data(rom_data));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ==========================================
    // compare and report
    task automatic chk_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // budget covers four rom copies of up to ~9k cycles plus the short boots
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            finish_test();
        end
    end

    // ==========================================
    // expected rom copy contents
    function automatic logic [7:0] rb(input logic [9:0] a);
        return a[7:0] ^ {a[9:8], 6'h25};
    endfunction

    function automatic logic [31:0] exp_word(input logic [7:0] idx, input logic [1:0] w,
                                             input logic be);
        logic [9:0] a;
        logic [7:0] b0, b1, b2, b3;
        a = {idx, 2'h0};
        b0 = rb(a);
        b1 = rb(a + 10'h1);
        b2 = rb(a + 10'h2);
        b3 = rb(a + 10'h3);
        if (be && w == 2'h0)
            return {b0, b1, b2, b3};
        if (be && w == 2'h1)
            return {b1, b0, b3, b2};
        return {b3, b2, b1, b0};
    endfunction

    // settled half a cycle after the launching edge
    always @(negedge mclk) begin
        if (rom_mon && mem_req === 1'b1) begin
            chk_word("rom dst", {22'h0, 8'(words_seen), 2'h0}, mem_addr);
            chk_word("rom word", exp_word(8'(words_seen), cur_w, cur_be), mem_wdata);
            chk_bit("rom we", 1'b1, mem_we);
            words_seen++;
        end
    end

    // ==========================================
    // access tasks
    task automatic do_reset(input logic [1:0] m, input logic [1:0] w, input logic be);
        rst_n <= 1'b0;
        boot_mode_sel <= m;
        rom_width_sel <= w;
        big_endian <= be;
        test_rst_drive_en <= 1'b0;
        test_rst_level <= 1'b0;
        repeat (7) @(posedge mclk);
        #1;
        chk_bit("core_rst_n", 1'b0, core_rst_n);
        chk_bit("cpu_stall", 1'b1, cpu_stall);
        chk_bit("cs_n", 1'b1, ext_chip_select_one_n);
        chk_bit("emu_rst_n", 1'b0, emu_logic_rst_n);
        chk_bit("dbg valid", 1'b0, debug_mode_valid);
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk_bit("core out", 1'b1, core_rst_n);
    endtask

    task automatic pulse_irq(input logic clr);
        @(posedge mclk);
        host_irq_set <= !clr;
        cpu_irq_clear <= clr;
        @(posedge mclk);
        host_irq_set <= 1'b0;
        cpu_irq_clear <= 1'b0;
        #1;
    endtask

    task automatic host_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        host_mem_req <= 1'b1;
        host_mem_we <= 1'b1;
        host_mem_addr <= a;
        host_mem_wdata <= d;
        @(posedge mclk);
        host_mem_req <= 1'b0;
        #1;
        chk_bit("mem_req", 1'b1, mem_req);
        chk_word("mem_addr", a, mem_addr);
        chk_word("mem_wdata", d, mem_wdata);
    endtask

    // ==========================================
    // scenarios
    initial begin
        {rst_n, big_endian, host_irq_set, cpu_irq_clear, host_mem_req, host_mem_we} = 6'h0;
        {test_rst_drive_en, test_rst_level, rom_mon, cur_be} = 4'h0;
        {boot_mode_sel, rom_width_sel, debug_mode_pins, cur_w} = 8'h0;
        host_mem_addr = 32'h0;
        host_mem_wdata = 32'h0;
        do_reset(2'h1, 2'h2, 1'b0);
        boot_mode_sel <= 2'h2;
        host_wr(32'h0000_0100, 32'hCAFE_0001);
        host_wr(32'h0180_0000, 32'h1234_5678);
        chk_bit("host stall", 1'b1, cpu_stall);
        chk_word("boot_mode", 32'h1, {30'h0, boot_mode});
        pulse_irq(1'b0);
        chk_bit("irq bit", 1'b1, host_to_cpu_irq);
        chk_bit("irq event", 1'b0, cpu_irq_event);
        @(posedge mclk);
        #1;
        chk_bit("stall off", 1'b0, cpu_stall);
        chk_bit("start", 1'b1, cpu_start);
        chk_word("start addr", 32'h0, cpu_start_addr);
        @(posedge mclk);
        #1;
        chk_bit("start pulse", 1'b0, cpu_start);
        pulse_irq(1'b0);
        chk_bit("irq while set", 1'b0, cpu_irq_event);
        pulse_irq(1'b1);
        chk_bit("irq cleared", 1'b0, host_to_cpu_irq);
        pulse_irq(1'b0);
        chk_bit("irq accepted", 1'b1, cpu_irq_event);
        test_rst_drive_en <= 1'b1;
        debug_mode_pins <= 2'h2;
        @(posedge mclk);
        test_rst_level <= 1'b1;
        repeat (2) @(posedge mclk);
        debug_mode_pins <= 2'h1;
        test_rst_level <= 1'b0;
        #1;
        chk_bit("dbg valid", 1'b1, debug_mode_valid);
        chk_word("dbg mode", 32'h2, {30'h0, debug_mode});
        repeat (2) @(posedge mclk);
        test_rst_level <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk_word("dbg relatch", 32'h2, {30'h0, debug_mode});
        do_reset(2'h0, 2'h2, 1'b0);
        repeat (4) @(posedge mclk);
        #1;
        chk_bit("emu stall", 1'b1, cpu_stall);
        pulse_irq(1'b0);
        @(posedge mclk);
        #1;
        chk_bit("emu run", 1'b0, cpu_stall);
        chk_bit("emu logic rst", 1'b0, emu_logic_rst_n);
        do_reset(2'h3, 2'h3, 1'b0);
        host_wr(32'h0000_0200, 32'h0BAD_F00D);
        chk_word("rsvd mode", 32'h3, {30'h0, boot_mode});
        chk_bit("rsvd stall", 1'b1, cpu_stall);
        pulse_irq(1'b0);
        @(posedge mclk);
        #1;
        chk_bit("rsvd run", 1'b0, cpu_stall);
        for (int i = 0; i < 4; i++) begin
            cur_w = (i == 0) ? 2'h0 : 2'(i - 1);
            cur_be = i[0];
            words_seen = 0;
            do_reset(2'h2, cur_w, cur_be);
            rom_mon = 1'b1;
            pulse_irq(1'b0);
            repeat (3) @(posedge mclk);
            #1;
            chk_bit("rom stall", 1'b1, cpu_stall);
            chk_bit("host held", 1'b0, host_mem_ready);
            for (int k = 0; k < 12000 && copy_done !== 1'b1; k++)
                @(posedge mclk);
            #1;
            chk_bit("copy_done", 1'b1, copy_done);
            chk_bit("rom release", 1'b0, cpu_stall);
            chk_word("word count", 32'd256, 32'(words_seen));
            rom_mon = 1'b0;
        end
        finish_test();
    end
endmodule
